/* logic/ecjm_map.svh */
// register indices, field positions, reset values and timing for the error/jitter meter
`ifndef ECJM_MAP_SVH
`define ECJM_MAP_SVH

// register indices; byte address is four times the index
`define ECJM_IDX_ERR_LOW 12'h023
`define ECJM_IDX_ERR_HIGH 12'h024
`define ECJM_IDX_ERR_CTRL 12'h025
`define ECJM_IDX_JM_CFG 12'h7E5
`define ECJM_IDX_POS_LOW 12'h7E6
`define ECJM_IDX_POS_HIGH 12'h7E7
`define ECJM_IDX_NEG_LOW 12'h7E8
`define ECJM_IDX_NEG_HIGH 12'h7E9
`define ECJM_IDX_INT_STAT 12'h7F0
`define ECJM_IDX_INT_MASK 12'h7F1

// jitter_meter_config fields
`define ECJM_FILTER_BAND_SELECT_BIT 0
`define ECJM_PERIOD_MODE_SELECT_BIT 1
`define ECJM_MANUAL_PERIOD_STOP_BIT 2
`define ECJM_JM_RESET 3'h0

// error control fields
`define ECJM_EC_UPDATE_BIT 0
`define ECJM_EC_MODE_BIT 1
`define ECJM_EC_RESET 1'h0

// interrupt status/mask fields
`define ECJM_INT_OVF_BIT 0
`define ECJM_INT_JIT_BIT 1
`define ECJM_INT_RESET 2'h0

// reset value of every result byte
`define ECJM_RESULT_RESET 8'h00

// automatic jitter period and the clock rate it is counted in
`define ECJM_AUTO_PERIOD_S 1
`define ECJM_CLK_HZ 250000000

// bus answers
`define ECJM_RESP_OKAY 2'h0
`define ECJM_RESP_SLVERR 2'h2

`endif

/* logic/ecjm_pkg.sv */
// types shared by the error/jitter meter files
package ecjm_pkg;
   typedef logic [11:0] ecjm_peak_t;
   typedef logic [15:0] ecjm_count_t;
   typedef logic [13:0] ecjm_addr_t;
endpackage

/* logic/ecjm_peak_track.sv */
// running positive and negative peak tracker for the demodulated jitter
`timescale 1ns/1ps
module ecjm_peak_track
   import ecjm_pkg::*;
#(
   parameter int SAMPLE_W = 13
) (
   // clock, reset, enable
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // samples
   input wire logic signed [SAMPLE_W-1:0] sample_i,
   input wire logic sample_valid_i,
   input wire logic restart_i,
   // running peaks
   output ecjm_peak_t pos_peak_o,
   output ecjm_peak_t neg_peak_o
);

   ecjm_peak_t pos_peak;
   ecjm_peak_t neg_peak;

   // elaboration check: wider samples would lose bits in the clip
   if (SAMPLE_W < 2 || SAMPLE_W > 13) begin : g_bad_width
      $error("sample width must be 2 to 13 bits");
   end

   // magnitude of a sample, clipped to twelve bits
   function automatic ecjm_peak_t clip_mag(input logic signed [SAMPLE_W-1:0] s);
      logic [SAMPLE_W-1:0] mag;
      mag = s[SAMPLE_W-1] ? SAMPLE_W'(-s) : SAMPLE_W'(s);
      if (mag > SAMPLE_W'(12'hFFF)) begin
         clip_mag = 12'hFFF;
      end else begin
         clip_mag = 12'(mag);
      end
   endfunction

   // restart takes precedence so the new period starts from zero
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         pos_peak <= 12'h000;
         neg_peak <= 12'h000;
      end else if (ce_i) begin
         if (restart_i) begin
            pos_peak <= 12'h000;
            neg_peak <= 12'h000;
         end else if (sample_valid_i) begin
            if (!sample_i[SAMPLE_W-1] && clip_mag(sample_i) > pos_peak) begin
               pos_peak <= clip_mag(sample_i);
            end
            if (sample_i[SAMPLE_W-1] && clip_mag(sample_i) > neg_peak) begin
               neg_peak <= clip_mag(sample_i);
            end
         end
      end
   end

   assign pos_peak_o = pos_peak;
   assign neg_peak_o = neg_peak;

endmodule

/* logic/ecjm_meter.sv */
// error tally and channel 0 jitter meter with AXI4-Lite register access
// Function
// - sixteen-bit error count readable as low and high byte, zero after reset
// - count bytes refresh automatically or on manual request, chosen by mode bit
// - period mode bit: 0 manual stop-ended, 1 one-second repeating; reset manual
// - stop bit rising edge latches peaks only in manual mode
// - band bit selects low or high jitter filter band
// - greatest positive peak reported as twelve bits, low byte plus high nibble
// - positive peak in UIpp equals twelve-bit value divided by sixteen
// - greatest negative peak reported likewise, twelve bits, scaled by sixteen
// - error counter overflow sets write-one-to-clear interrupt flag
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "ecjm_map.svh"
module ecjm_meter
   import ecjm_pkg::*;
#(
   parameter int unsigned PERIOD_CYCLES = `ECJM_AUTO_PERIOD_S * `ECJM_CLK_HZ,
   parameter int SAMPLE_W = 13
) (
   // clock, reset, enable
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // error events and round boundary from the pattern checker
   input wire logic error_event_i,
   input wire logic round_end_i,
   // demodulated jitter of channel 0
   input wire logic signed [SAMPLE_W-1:0] jitter_sample_i,
   input wire logic jitter_valid_i,
   // filter control
   output logic filter_band_select_o,
   // interrupt
   output logic irq_o,
   // axi4-lite write address
   input wire logic [13:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [13:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // elaboration checks: the counter needs two states, the tracker a sample it can clip
   if (PERIOD_CYCLES < 2) begin : g_bad_period
      $error("automatic period must be at least two cycles");
   end
   if (SAMPLE_W < 2 || SAMPLE_W > 13) begin : g_bad_sample
      $error("jitter sample width must be 2 to 13 bits");
   end

   // index of a byte address, or all ones when misaligned
   function automatic logic [11:0] addr_index(input ecjm_addr_t a);
      addr_index = (a[1:0] == 2'h0) ? a[13:2] : 12'hFFF;
   endfunction

   // true for every index that has a register behind it
   function automatic logic is_mapped(input logic [11:0] idx);
      is_mapped = idx == `ECJM_IDX_ERR_LOW || idx == `ECJM_IDX_ERR_HIGH ||
         idx == `ECJM_IDX_ERR_CTRL || idx == `ECJM_IDX_JM_CFG ||
         idx == `ECJM_IDX_POS_LOW || idx == `ECJM_IDX_POS_HIGH ||
         idx == `ECJM_IDX_NEG_LOW || idx == `ECJM_IDX_NEG_HIGH ||
         idx == `ECJM_IDX_INT_STAT || idx == `ECJM_IDX_INT_MASK;
   endfunction

   // zero-extend a byte or a nibble into a bus word; upper bits read zero
   function automatic logic [31:0] byte_word(input logic [7:0] b);
      byte_word = {24'h000000, b};
   endfunction

   function automatic logic [31:0] small_word(input logic [3:0] n);
      small_word = {28'h0000000, n};
   endfunction

   // bus state
   ecjm_addr_t aw_addr;
   logic aw_held;
   logic [7:0] w_byte;
   logic w_lane0;
   logic w_held;
   logic wr_fire;
   logic wr_ok;
   logic [11:0] wr_idx;

   // block state
   logic counting_mode_select;
   logic manual_update;
   logic [2:0] jitter_meter_config;
   ecjm_count_t error_tally;
   ecjm_count_t error_latched;
   ecjm_peak_t positive_peak_value;
   ecjm_peak_t negative_peak_value;
   ecjm_peak_t run_pos;
   ecjm_peak_t run_neg;
   logic [31:0] period_count;
   logic period_done;
   logic stop_rise;
   logic peak_latch;
   logic count_latch;
   logic overflow_event;
   logic [1:0] int_status;
   logic [1:0] int_mask;

   // ce_i low freezes the bus registers but not the ready outputs, so a request offered then is lost
   // write channels are taken independently and held until both are present
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_idx = addr_index(aw_addr);
   // a write with lane 0 off is answered but changes nothing
   assign wr_ok = wr_fire && w_lane0;

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         aw_held <= 1'b0;
         aw_addr <= 14'h0000;
      end else if (ce_i) begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (ce_i) begin
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // write response; unmapped or misaligned addresses answer with slverr
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ECJM_RESP_OKAY;
      end else if (ce_i) begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (is_mapped(wr_idx)) begin
               s_axi_bresp <= `ECJM_RESP_OKAY;
            end else begin
               s_axi_bresp <= `ECJM_RESP_SLVERR;
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // error control: mode bit holds, update bit is a write pulse only
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         counting_mode_select <= `ECJM_EC_RESET;
         manual_update <= 1'b0;
      end else if (ce_i) begin
         manual_update <= 1'b0;
         if (wr_ok && wr_idx == `ECJM_IDX_ERR_CTRL) begin
            counting_mode_select <= w_byte[`ECJM_EC_MODE_BIT];
            manual_update <= w_byte[`ECJM_EC_UPDATE_BIT];
         end
      end
   end

   // config keeps only bits 2..0, so upper bits never store
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         jitter_meter_config <= `ECJM_JM_RESET;
      end else if (ce_i) begin
         if (wr_ok && wr_idx == `ECJM_IDX_JM_CFG) begin
            jitter_meter_config <= w_byte[2:0];
         end
      end
   end

   // stop rise counts only while the period is manual
   assign stop_rise = wr_ok && wr_idx == `ECJM_IDX_JM_CFG &&
      w_byte[`ECJM_MANUAL_PERIOD_STOP_BIT] && !jitter_meter_config[`ECJM_MANUAL_PERIOD_STOP_BIT] &&
      !jitter_meter_config[`ECJM_PERIOD_MODE_SELECT_BIT];
   assign filter_band_select_o = jitter_meter_config[`ECJM_FILTER_BAND_SELECT_BIT];

   // one-second period counter; held at zero in manual mode
   assign period_done = jitter_meter_config[`ECJM_PERIOD_MODE_SELECT_BIT] &&
      period_count == PERIOD_CYCLES - 1;
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         period_count <= 32'h00000000;
      end else if (ce_i) begin
         if (!jitter_meter_config[`ECJM_PERIOD_MODE_SELECT_BIT] || period_done) begin
            period_count <= 32'h00000000;
         end else begin
            period_count <= period_count + 32'h00000001;
         end
      end
   end

   assign peak_latch = period_done || stop_rise;

   // running peaks restart with each latched result
   ecjm_peak_track #(
      .SAMPLE_W(SAMPLE_W)
   ) u_peak (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .sample_i(jitter_sample_i),
      .sample_valid_i(jitter_valid_i),
      .restart_i(peak_latch),
      .pos_peak_o(run_pos),
      .neg_peak_o(run_neg)
   );

   // visible peaks; a new result overwrites an unread one
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         positive_peak_value <= 12'h000;
         negative_peak_value <= 12'h000;
      end else if (ce_i) begin
         if (peak_latch) begin
            positive_peak_value <= run_pos;
            negative_peak_value <= run_neg;
         end
      end
   end

   // round end source follows the counting mode
   assign count_latch = counting_mode_select ? manual_update : round_end_i;
   assign overflow_event = ce_i && error_event_i && !count_latch &&
      error_tally == 16'hFFFF;

   // tally saturates rather than wrapping so an overflowed count reads full, never small
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         error_tally <= 16'h0000;
         error_latched <= 16'h0000;
      end else if (ce_i) begin
         if (count_latch) begin
            error_latched <= error_tally;
            error_tally <= error_event_i ? 16'h0001 : 16'h0000;
         end else if (error_event_i && error_tally != 16'hFFFF) begin
            error_tally <= error_tally + 16'h0001;
         end
      end
   end

   // sticky status; an event in the clearing cycle wins
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         int_status <= `ECJM_INT_RESET;
      end else if (ce_i) begin
         for (int i = 0; i < 2; i++) begin
            if ((i == `ECJM_INT_OVF_BIT && overflow_event) ||
                (i == `ECJM_INT_JIT_BIT && peak_latch)) begin
               int_status[i] <= 1'b1;
            end else if (wr_ok && wr_idx == `ECJM_IDX_INT_STAT &&
                         w_byte[i]) begin
               int_status[i] <= 1'b0;
            end
         end
      end
   end

   // mask: a one routes the matching status bit to irq_o
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         int_mask <= `ECJM_INT_RESET;
      end else if (ce_i) begin
         if (wr_ok && wr_idx == `ECJM_IDX_INT_MASK) begin
            int_mask <= w_byte[1:0];
         end
      end
   end

   // irq is a gate of registers, so it moves the cycle after the write lands
   assign irq_o = |(int_status & int_mask);

   // read channel: one read at a time, data registered
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `ECJM_RESP_OKAY;
      end else if (ce_i) begin
         if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `ECJM_RESP_OKAY;
            if (addr_index(s_axi_araddr) == `ECJM_IDX_ERR_LOW) begin
               s_axi_rdata <= byte_word(error_latched[7:0]);
            end else if (addr_index(s_axi_araddr) == `ECJM_IDX_ERR_HIGH) begin
               s_axi_rdata <= byte_word(error_latched[15:8]);
            end else if (addr_index(s_axi_araddr) == `ECJM_IDX_ERR_CTRL) begin
               s_axi_rdata <= small_word({2'h0, counting_mode_select, 1'b0});
            end else if (addr_index(s_axi_araddr) == `ECJM_IDX_JM_CFG) begin
               s_axi_rdata <= small_word({1'b0, jitter_meter_config});
            end else if (addr_index(s_axi_araddr) == `ECJM_IDX_POS_LOW) begin
               s_axi_rdata <= byte_word(positive_peak_value[7:0]);
            end else if (addr_index(s_axi_araddr) == `ECJM_IDX_POS_HIGH) begin
               s_axi_rdata <= small_word(positive_peak_value[11:8]);
            end else if (addr_index(s_axi_araddr) == `ECJM_IDX_NEG_LOW) begin
               s_axi_rdata <= byte_word(negative_peak_value[7:0]);
            end else if (addr_index(s_axi_araddr) == `ECJM_IDX_NEG_HIGH) begin
               s_axi_rdata <= small_word(negative_peak_value[11:8]);
            end else if (addr_index(s_axi_araddr) == `ECJM_IDX_INT_STAT) begin
               s_axi_rdata <= small_word({2'h0, int_status});
            end else if (addr_index(s_axi_araddr) == `ECJM_IDX_INT_MASK) begin
               s_axi_rdata <= small_word({2'h0, int_mask});
            end else begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `ECJM_RESP_SLVERR;
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

/* bench/ecjm_meter_sva.sv */
// checker for the error/jitter meter bus handshakes and outputs
`timescale 1ns/1ps
module ecjm_meter_sva (
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // outputs
   input wire logic filter_band_select_o,
   input wire logic irq_o,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // one clock domain for every check
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);

   // address and data taken at one edge
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence

   // write answer comes two edges after the take, not one
   a_wr_quiet: assert property (s_wr_take |=> !s_axi_bvalid)
      else $error("write response too early");
   a_wr_answer: assert property (s_wr_take ##1 ce_i ##1 ce_i |-> s_axi_bvalid)
      else $error("write response missing");
   a_rd_answer: assert property (s_rd_take ##1 ce_i |-> s_axi_rvalid)
      else $error("read data missing");
   a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   a_b_release: assert property (s_axi_bvalid && s_axi_bready && ce_i |=> !s_axi_bvalid)
      else $error("write response not released");
   a_r_release: assert property (s_axi_rvalid && s_axi_rready && ce_i |=> !s_axi_rvalid)
      else $error("read data not released");
   // band output only moves with a completed register write
   a_band_write: assert property ($changed(filter_band_select_o) |-> $rose(s_axi_bvalid))
      else $error("band select changed without a write");
   // irq only drops by a clear or mask write
   a_irq_clear: assert property ($fell(irq_o) |-> $rose(s_axi_bvalid))
      else $error("interrupt dropped without a write");
endmodule

bind ecjm_meter ecjm_meter_sva ecjm_meter_sva_inst (
   .clock_i, .reset_i, .ce_i, .filter_band_select_o, .irq_o,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready
);

/* bench/tb.sv */
// self-checking bench for the error/jitter meter
`timescale 1ns/1ps
`include "ecjm_map.svh"
module tb;
   import ecjm_pkg::*;
   logic clock_i, reset_i, ce_i, error_event_i, round_end_i, jitter_valid_i;
   logic [3:0] s_axi_wstrb;
   logic signed [12:0] jitter_sample_i;
   logic filter_band_select_o, irq_o;
   logic [13:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   int failures, n_checks;

   // short period keeps the automatic round fast
   ecjm_meter #(.PERIOD_CYCLES(20)) ecjm_meter_inst (
      .clock_i, .reset_i, .ce_i, .error_event_i, .round_end_i, .jitter_sample_i,
      .jitter_valid_i, .filter_band_select_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );

   // 250 MHz clock
   initial begin
      clock_i = 0;
      forever #2 clock_i = ~clock_i;
   end

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // ready sampled at the falling edge, so no race with the rising one
   task wr(input logic [11:0] idx, input logic [7:0] d);
      logic pa, pw, ta, tw, got;
      pa = 1;
      pw = 1;
      got = 0;
      @(posedge clock_i);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (pa || pw) begin
         @(negedge clock_i);
         ta = pa && s_axi_awready;
         tw = pw && s_axi_wready;
         @(posedge clock_i);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      while (!got) begin
         @(negedge clock_i);
         got = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge clock_i);
      end
      s_axi_bready <= 0;
   endtask

   task rd(input logic [11:0] idx);
      logic got;
      got = 0;
      @(posedge clock_i);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      while (!got) begin
         @(negedge clock_i);
         got = s_axi_arready;
         @(posedge clock_i);
      end
      s_axi_arvalid <= 0;
      got = 0;
      while (!got) begin
         @(negedge clock_i);
         got = s_axi_rvalid;
         rd_v = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge clock_i);
      end
      s_axi_rready <= 0;
   endtask

   task rc(input string nm, input logic [11:0] idx, input logic [31:0] exp);
      rd(idx);
      chk(nm, rd_v, exp);
   endtask

   task errs(input int n);
      repeat (n) begin
         @(posedge clock_i);
         error_event_i <= 1;
      end
      @(posedge clock_i);
      error_event_i <= 0;
      @(negedge clock_i);
   endtask

   task round_pulse;
      @(posedge clock_i);
      round_end_i <= 1;
      @(posedge clock_i);
      round_end_i <= 0;
   endtask

   task jset(input logic signed [12:0] v, input int n);
      @(posedge clock_i);
      jitter_sample_i <= v;
      jitter_valid_i <= 1;
      repeat (n) @(posedge clock_i);
      jitter_valid_i <= 0;
   endtask

   task t_reset;
      logic [11:0] idx [10];
      idx = '{12'h023, 12'h024, 12'h025, 12'h7E5, 12'h7E6,
              12'h7E7, 12'h7E8, 12'h7E9, 12'h7F0, 12'h7F1};
      foreach (idx[i]) rc("reset value", idx[i], 32'h0);
      chk("band", filter_band_select_o, 1'b0);
   endtask

   // automatic then manual transfer of the tally
   task t_count;
      errs(259);
      round_pulse;
      rc("count low", `ECJM_IDX_ERR_LOW, 32'h03);
      rc("count high", `ECJM_IDX_ERR_HIGH, 32'h01);
      wr(`ECJM_IDX_ERR_CTRL, 8'h02);
      errs(2);
      round_pulse;
      rc("held low", `ECJM_IDX_ERR_LOW, 32'h03);
      wr(`ECJM_IDX_ERR_CTRL, 8'h03);
      rc("manual low", `ECJM_IDX_ERR_LOW, 32'h02);
      rc("manual high", `ECJM_IDX_ERR_HIGH, 32'h00);
   endtask

   // tally restarted at zero, so the 65536th error overflows
   task t_overflow;
      wr(`ECJM_IDX_INT_MASK, 8'h01);
      errs(65535);
      chk("irq at full", irq_o, 1'b0);
      errs(1);
      chk("irq overflow", irq_o, 1'b1);
      rc("status", `ECJM_IDX_INT_STAT, 32'h1);
      wr(`ECJM_IDX_INT_MASK, 8'h00);
      chk("irq masked", irq_o, 1'b0);
      wr(`ECJM_IDX_INT_MASK, 8'h01);
      chk("irq unmasked", irq_o, 1'b1);
      wr(`ECJM_IDX_INT_STAT, 8'h01);
      chk("irq cleared", irq_o, 1'b0);
      wr(`ECJM_IDX_ERR_LOW, 8'hFF);
      rc("ro count", `ECJM_IDX_ERR_LOW, 32'h02);
      wr(12'h100, 8'hFF);
      chk("unmapped wr", resp, `ECJM_RESP_SLVERR);
      rc("unmapped rd", 12'h100, 32'h0);
      chk("unmapped rresp", resp, `ECJM_RESP_SLVERR);
   endtask

   task t_manual_jit;
      jset(13'sd40, 3);
      jset(-13'sd300, 3);
      wr(`ECJM_IDX_JM_CFG, 8'h04);
      rc("pos low", `ECJM_IDX_POS_LOW, 32'h28);
      rc("pos high", `ECJM_IDX_POS_HIGH, 32'h0);
      rc("neg low", `ECJM_IDX_NEG_LOW, 32'h2C);
      rc("neg high", `ECJM_IDX_NEG_HIGH, 32'h1);
      rc("jit status", `ECJM_IDX_INT_STAT, 32'h2);
      jset(13'sd291, 3);
      wr(`ECJM_IDX_JM_CFG, 8'h04);
      rc("no rise", `ECJM_IDX_POS_LOW, 32'h28);
      wr(`ECJM_IDX_JM_CFG, 8'h00);
      wr(`ECJM_IDX_JM_CFG, 8'h04);
      rc("pos low 2", `ECJM_IDX_POS_LOW, 32'h23);
      rc("pos high 2", `ECJM_IDX_POS_HIGH, 32'h1);
      rc("neg restart", `ECJM_IDX_NEG_LOW, 32'h0);
   endtask

   // repeating rounds follow the live samples
   task t_auto_jit;
      @(posedge clock_i);
      jitter_sample_i <= 13'sd85;
      jitter_valid_i <= 1;
      wr(`ECJM_IDX_JM_CFG, 8'h02);
      repeat (60) @(posedge clock_i);
      rc("auto peak", `ECJM_IDX_POS_LOW, 32'h55);
      jitter_valid_i <= 0;
      repeat (60) @(posedge clock_i);
      rc("auto repeat", `ECJM_IDX_POS_LOW, 32'h00);
   endtask

   task t_cfg;
      wr(`ECJM_IDX_JM_CFG, 8'hFF);
      rc("cfg reserved", `ECJM_IDX_JM_CFG, 32'h07);
      chk("band high", filter_band_select_o, 1'b1);
      wr(`ECJM_IDX_JM_CFG, 8'h00);
      chk("band low", filter_band_select_o, 1'b0);
   endtask

   // lane 0 off leaves the register alone; enable low freezes the tally
   task t_hold;
      s_axi_wstrb <= 4'h0;
      wr(`ECJM_IDX_JM_CFG, 8'h01);
      s_axi_wstrb <= 4'hF;
      chk("strobe off", filter_band_select_o, 1'b0);
      chk("strobe resp", resp, `ECJM_RESP_OKAY);
      wr(`ECJM_IDX_ERR_CTRL, 8'h03);
      rc("full low", `ECJM_IDX_ERR_LOW, 32'hFF);
      ce_i <= 0;
      errs(5);
      @(posedge clock_i);
      ce_i <= 1;
      errs(2);
      wr(`ECJM_IDX_ERR_CTRL, 8'h03);
      rc("frozen tally", `ECJM_IDX_ERR_LOW, 32'h02);
   endtask

   task end_of_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // hang guard, well past the expected run yet inside the cycle budget
   initial begin
      #380000;
      failures++;
      end_of_test;
   end

   // reset, then scenarios in order
   initial begin
      {reset_i, ce_i, error_event_i, round_end_i, jitter_valid_i, jitter_sample_i} = {2'b11, 16'h0};
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 60'h0;
      repeat (4) @(posedge clock_i);
      reset_i <= 0;
      t_reset;
      t_count;
      t_overflow;
      t_manual_jit;
      t_auto_jit;
      t_cfg;
      t_hold;
      end_of_test;
   end
endmodule
